/* File: hw/cow_option_zero.sv */
// What this block does
// - period field 00 disables watchdog; 01, 10, 11 give 5, 88, 175 s
// - period field sits in bits 14:13 and resets to 11
// - no charge write within period forces charge current to zero
// - after expiry, charge writes or period field write restart the timer
// - auto-off set and battery input falling clears loop enable bit 1
// - host may write loop enable back to 1 after auto clear
// - auto-off clear (default) leaves loop enable untouched on battery fall
// - reverse-mode power-good bit drives source-good high in OTG mode
// - low power bit with battery only turns off regulator, monitors, ADC
// - in low power, throttle enable keeps comparator and throttle profile
// - low power bit clear with battery only runs performance mode
// - audio-band avoid bit clamps minimum burst frequency near 25 kHz
// - switching-rate bit 0 selects 800 kHz, 1 selects 400 kHz
// - pass-through ripple bit enables ripple reduction, default on
// - host writes loop enable; it reads low after automatic clear
module cow_option_zero #(
    parameter logic [32:0] WD_SHORT_CYCLES = cow_pkg::WD_SHORT_CYCLES,
    parameter logic [32:0] WD_MID_CYCLES = cow_pkg::WD_MID_CYCLES,
    parameter logic [32:0] WD_LONG_CYCLES = cow_pkg::WD_LONG_CYCLES
) (
    // clock, reset, clock enable
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CE,
    // register port from the serial interface engine
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    // pins
    input wire logic BATTERY_PRESENT_N,
    input wire logic ADAPTER_PRESENT,
    input wire logic OTG_MODE,
    // from another option register, same clock
    input wire logic LOWPOWER_THROTTLE_ENABLE,
    // power-good and watchdog
    output logic SOURCE_GOOD_OUTPUT,
    output logic CHARGE_CURRENT_CLEAR,
    output logic WATCHDOG_EXPIRED,
    // converter controls
    output logic INPUT_LIMIT_LOOP_ENABLE,
    output logic LOW_POWER_ACTIVE,
    output logic INTERNAL_REGULATOR_ENABLE,
    output logic THROTTLE_ALERT_ENABLE,
    output logic MONITOR_BUFFER_ENABLE,
    output logic COMPARATOR_ENABLE,
    output logic ADC_ENABLE,
    output logic AUDIO_BAND_CLAMP,
    output logic SWITCH_AT_400K,
    output logic RIPPLE_REDUCE
);

    typedef struct packed {
        logic [15:0] opt;
        logic [15:0] rdata;
        logic batt_s1;
        logic batt_s2;
        logic batt_d;
        logic adp_s1;
        logic adp_s2;
        logic otg_s1;
        logic otg_s2;
        logic src_good;
        logic lp;
        logic reg_en;
        logic thr_en;
        logic mon_en;
        logic cmp_en;
        logic adc_en;
    } cow_top_st_t;

    // period field resets to 11
    // sync flops start as battery attached, no adapter, no OTG
    localparam cow_top_st_t RESET_ST = '{
        opt: cow_pkg::OPTION0_RESET, rdata: 16'h0,
        batt_s1: 1'b1, batt_s2: 1'b1, batt_d: 1'b1,
        adp_s1: 1'b0, adp_s2: 1'b0, otg_s1: 1'b0, otg_s2: 1'b0,
        src_good: 1'b0, lp: 1'b0, reg_en: 1'b1, thr_en: 1'b1,
        mon_en: 1'b1, cmp_en: 1'b1, adc_en: 1'b1};

    cow_top_st_t s;
    cow_top_st_t next_s;
    logic wr_opt;
    logic wr_charge;
    logic batt_fall;
    logic wd_kick;
    logic wd_expire;
    logic wd_expired;
    logic lp_now;

    always_comb begin
        wr_opt = REG_WR && REG_ADDR == cow_pkg::ADDR_OPTION0;
        wr_charge = REG_WR && (REG_ADDR == cow_pkg::ADDR_CHG_CURRENT ||
            REG_ADDR == cow_pkg::ADDR_CHG_VOLTAGE);
        // battery leaving shows as the synced pin falling
        batt_fall = s.batt_d && !s.batt_s2;
        wd_kick = wr_charge || (wr_opt && (wd_expired ||
            REG_WDATA[cow_pkg::BIT_WD_PERIOD_HI:cow_pkg::BIT_WD_PERIOD_LO]
            != s.opt[cow_pkg::BIT_WD_PERIOD_HI:cow_pkg::BIT_WD_PERIOD_LO]));
        lp_now = s.opt[cow_pkg::BIT_LOW_POWER_ENABLE] && !s.adp_s2 &&
            s.batt_s2;

        next_s = s;
        // second stage is the only reader of each first stage
        next_s.batt_s1 = BATTERY_PRESENT_N;
        next_s.batt_s2 = s.batt_s1;
        next_s.batt_d = s.batt_s2;
        next_s.adp_s1 = ADAPTER_PRESENT;
        next_s.adp_s2 = s.adp_s1;
        next_s.otg_s1 = OTG_MODE;
        next_s.otg_s2 = s.otg_s1;

        if (wr_opt) begin
            next_s.opt = REG_WDATA;
        end
        if (s.opt[cow_pkg::BIT_INPUT_LIMIT_AUTO_OFF] && batt_fall) begin
            // hardware clear wins over a same-cycle host write
            next_s.opt[cow_pkg::BIT_INPUT_LIMIT_LOOP_ENABLE] = 1'b0;
        end

        // reads return the value before any same-cycle write
        next_s.rdata = (REG_ADDR == cow_pkg::ADDR_OPTION0) ? s.opt :
            16'h0;

        next_s.src_good = s.adp_s2 || (s.otg_s2 &&
            s.opt[cow_pkg::BIT_REVERSE_MODE_POWER_GOOD]);

        // performance mode when lp is off
        next_s.lp = lp_now;
        next_s.reg_en = !lp_now;
        next_s.mon_en = !lp_now;
        next_s.adc_en = !lp_now;
        next_s.cmp_en = !lp_now || LOWPOWER_THROTTLE_ENABLE;
        next_s.thr_en = !lp_now || LOWPOWER_THROTTLE_ENABLE;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s <= RESET_ST;
        end else if (CE) begin
            s <= next_s;
        end
    end

    cow_watchdog #(
        .SHORT_CYCLES(WD_SHORT_CYCLES),
        .MID_CYCLES(WD_MID_CYCLES),
        .LONG_CYCLES(WD_LONG_CYCLES)
    ) u_watchdog (
        .clk(MCLK),
        .rst_n(NRST),
        .ce(CE),
        .period_sel(
            s.opt[cow_pkg::BIT_WD_PERIOD_HI:cow_pkg::BIT_WD_PERIOD_LO]),
        .kick(wd_kick),
        .expire(wd_expire),
        .expired(wd_expired)
    );

    assign REG_RDATA = s.rdata;
    assign SOURCE_GOOD_OUTPUT = s.src_good;
    assign CHARGE_CURRENT_CLEAR = wd_expire;
    assign WATCHDOG_EXPIRED = wd_expired;
    assign INPUT_LIMIT_LOOP_ENABLE =
        s.opt[cow_pkg::BIT_INPUT_LIMIT_LOOP_ENABLE];
    assign LOW_POWER_ACTIVE = s.lp;
    assign INTERNAL_REGULATOR_ENABLE = s.reg_en;
    assign THROTTLE_ALERT_ENABLE = s.thr_en;
    assign MONITOR_BUFFER_ENABLE = s.mon_en;
    assign COMPARATOR_ENABLE = s.cmp_en;
    assign ADC_ENABLE = s.adc_en;
    assign AUDIO_BAND_CLAMP = s.opt[cow_pkg::BIT_AUDIO_BAND_AVOID];
    // rate select, 1 means 400 kHz
    assign SWITCH_AT_400K = s.opt[cow_pkg::BIT_SWITCHING_RATE];
    assign RIPPLE_REDUCE = s.opt[cow_pkg::BIT_PASSTHROUGH_RIPPLE];

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence seq_batt_leave;
        CE && batt_fall;
    endsequence

    sequence seq_opt_write;
        CE && wr_opt;
    endsequence

    sequence seq_opt_read;
        CE && REG_ADDR == cow_pkg::ADDR_OPTION0;
    endsequence

    sequence seq_batt_only;
        CE && s.opt[15] && !s.adp_s2 && s.batt_s2;
    endsequence

    wd_field_a: assert property (
        seq_opt_write and !batt_fall
        |=> s.opt[14:13] == $past(REG_WDATA[14:13]))
        else $error("watchdog period field not stored");

    wd_clear_a: assert property (
        CE && CHARGE_CURRENT_CLEAR |-> WATCHDOG_EXPIRED
        ##1 !CHARGE_CURRENT_CLEAR)
        else $error("charge clear pulse malformed");

    auto_clear_a: assert property (
        seq_batt_leave and s.opt[12] |=> !INPUT_LIMIT_LOOP_ENABLE)
        else $error("loop enable not cleared on battery leave");

    reenable_a: assert property (
        seq_opt_write and REG_WDATA[1] && !(batt_fall && s.opt[12])
        |=> INPUT_LIMIT_LOOP_ENABLE)
        else $error("host re-enable of loop ignored");

    keep_loop_a: assert property (
        seq_batt_leave and !s.opt[12] && !wr_opt
        |=> $stable(INPUT_LIMIT_LOOP_ENABLE))
        else $error("loop enable changed with auto-off clear");

    otg_good_a: assert property (
        CE && s.otg_s2 && s.opt[11] |=> SOURCE_GOOD_OUTPUT)
        else $error("source good low in OTG with steering set");

    low_power_a: assert property (
        seq_batt_only |=> LOW_POWER_ACTIVE && !INTERNAL_REGULATOR_ENABLE
        && !ADC_ENABLE && !MONITOR_BUFFER_ENABLE)
        else $error("blocks left on in low power");

    lp_throttle_a: assert property (
        CE && LOWPOWER_THROTTLE_ENABLE |=> COMPARATOR_ENABLE
        && THROTTLE_ALERT_ENABLE)
        else $error("comparator off despite throttle enable");

    perf_mode_a: assert property (
        CE && !s.opt[15] |=> !LOW_POWER_ACTIVE && ADC_ENABLE)
        else $error("low power active with bit clear");

    charge_kick_a: assert property (
        CE && wr_charge && s.opt[14:13] != 2'h0 |=> !WATCHDOG_EXPIRED)
        else $error("charge write did not restart watchdog");

    lp_cmp_off_a: assert property (
        seq_batt_only and !LOWPOWER_THROTTLE_ENABLE
        |=> !COMPARATOR_ENABLE && !THROTTLE_ALERT_ENABLE)
        else $error("comparator left on in low power");

    // no OTG drive when bit clear
    otg_quiet_a: assert property (
        CE && !s.adp_s2 && !s.opt[11] |=> !SOURCE_GOOD_OUTPUT)
        else $error("source good high with steering clear");

    perf_buffers_a: assert property (
        CE && !s.opt[15] |=> INTERNAL_REGULATOR_ENABLE
        && MONITOR_BUFFER_ENABLE)
        else $error("buffers off in performance mode");

    audio_clamp_a: assert property (
        seq_opt_write |=> AUDIO_BAND_CLAMP == $past(REG_WDATA[10]))
        else $error("audio clamp does not follow its bit");

    rate_select_a: assert property (
        seq_opt_write |=> SWITCH_AT_400K == $past(REG_WDATA[9]))
        else $error("switching rate does not follow its bit");

    ripple_follow_a: assert property (
        seq_opt_write |=> RIPPLE_REDUCE == $past(REG_WDATA[8]))
        else $error("ripple reduction does not follow its bit");

    loop_read_a: assert property (
        seq_opt_read |=> REG_RDATA[1] == $past(INPUT_LIMIT_LOOP_ENABLE))
        else $error("loop enable read back wrong");

    unmapped_read_a: assert property (
        CE && REG_ADDR != cow_pkg::ADDR_OPTION0 |=> REG_RDATA == 16'h0)
        else $error("unmapped address read not zero");

endmodule : cow_option_zero

/* File: hw/cow_pkg.sv */
package cow_pkg;

    // register addresses on the serial register port
    localparam logic [7:0] ADDR_OPTION0 = 8'h00;
    localparam logic [7:0] ADDR_CHG_CURRENT = 8'h02;
    localparam logic [7:0] ADDR_CHG_VOLTAGE = 8'h04;

    // charge_option_zero value after power-on reset
    localparam logic [15:0] OPTION0_RESET = 16'he70e;

    // field positions in charge_option_zero
    localparam int BIT_LOW_POWER_ENABLE = 15;
    localparam int BIT_WD_PERIOD_HI = 14;
    localparam int BIT_WD_PERIOD_LO = 13;
    localparam int BIT_INPUT_LIMIT_AUTO_OFF = 12;
    localparam int BIT_REVERSE_MODE_POWER_GOOD = 11;
    localparam int BIT_AUDIO_BAND_AVOID = 10;
    localparam int BIT_SWITCHING_RATE = 9;
    localparam int BIT_PASSTHROUGH_RIPPLE = 8;
    localparam int BIT_INPUT_LIMIT_LOOP_ENABLE = 1;

    // watchdog_period_select codes
    typedef enum logic [1:0] {
        COW_WD_OFF = 2'h0,
        COW_WD_SHORT = 2'h1,
        COW_WD_MID = 2'h2,
        COW_WD_LONG = 2'h3
    } cow_wd_sel_t;

    // watchdog states
    typedef enum logic [2:0] {
        COW_WD_IDLE = 3'h1,
        COW_WD_RUN = 3'h2,
        COW_WD_EXPIRED = 3'h4
    } cow_wd_state_t;

    // clock rate and watchdog periods
    localparam longint CLK_HZ = 25_000_000;
    localparam longint WD_SHORT_S = 5;
    localparam longint WD_MID_S = 88;
    localparam longint WD_LONG_S = 175;
    localparam logic [32:0] WD_SHORT_CYCLES = 33'(WD_SHORT_S * CLK_HZ);
    localparam logic [32:0] WD_MID_CYCLES = 33'(WD_MID_S * CLK_HZ);
    localparam logic [32:0] WD_LONG_CYCLES = 33'(WD_LONG_S * CLK_HZ);

endpackage : cow_pkg

/* File: hw/cow_watchdog.sv */
module cow_watchdog #(
    parameter logic [32:0] SHORT_CYCLES = cow_pkg::WD_SHORT_CYCLES,
    parameter logic [32:0] MID_CYCLES = cow_pkg::WD_MID_CYCLES,
    parameter logic [32:0] LONG_CYCLES = cow_pkg::WD_LONG_CYCLES
) (
    // clock, reset, clock enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic [1:0] period_sel,
    input wire logic kick,
    // status
    output logic expire,
    output logic expired
);

    typedef struct packed {
        cow_pkg::cow_wd_state_t state;
        logic [32:0] cnt;
        logic expire;
        logic expired;
    } cow_wd_st_t;

    localparam cow_wd_st_t RESET_ST = '{
        state: cow_pkg::COW_WD_IDLE, cnt: 33'h0, expire: 1'b0,
        expired: 1'b0};

    cow_wd_st_t s;
    cow_wd_st_t next_s;
    logic [32:0] limit;

    always_comb begin
        unique case (period_sel)
            cow_pkg::COW_WD_SHORT: limit = SHORT_CYCLES;
            cow_pkg::COW_WD_MID: limit = MID_CYCLES;
            default: limit = LONG_CYCLES;
        endcase
        next_s = s;
        next_s.expire = 1'b0;
        if (period_sel == cow_pkg::COW_WD_OFF) begin
            next_s.state = cow_pkg::COW_WD_IDLE;
            next_s.cnt = 33'h0;
        end else if (kick) begin
            next_s.state = cow_pkg::COW_WD_RUN;
            next_s.cnt = 33'h0;
        end else begin
            unique case (s.state)
                cow_pkg::COW_WD_IDLE: begin
                    next_s.state = cow_pkg::COW_WD_RUN;
                    next_s.cnt = 33'h0;
                end
                cow_pkg::COW_WD_RUN: begin
                    // >= so a shortened period still expires
                    if (s.cnt >= 33'(limit - 33'h1)) begin
                        next_s.state = cow_pkg::COW_WD_EXPIRED;
                        next_s.cnt = 33'h0;
                        next_s.expire = 1'b1;
                    end else begin
                        next_s.cnt = 33'(s.cnt + 33'h1);
                    end
                end
                cow_pkg::COW_WD_EXPIRED: next_s.state = s.state;
                default: next_s = RESET_ST;
            endcase
        end
        // level kept in its own flop so the output needs no decode
        next_s.expired = next_s.state == cow_pkg::COW_WD_EXPIRED;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= RESET_ST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign expire = s.expire;
    assign expired = s.expired;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wd_disabled_a: assert property (
        ce && period_sel == 2'h0 |=> !expire && !expired)
        else $error("watchdog expired while disabled");

    kick_restart_a: assert property (
        ce && kick && period_sel != 2'h0 |=> s.cnt == 33'h0 && !expired)
        else $error("watchdog kick did not restart the count");

    expiry_hold_a: assert property (
        ce && expired && !kick && period_sel != 2'h0 |=> expired && !expire)
        else $error("expired watchdog left state without a kick");

endmodule : cow_watchdog

/* File: verification/cow_host_model.sv */
module cow_host_model (
    // clock
    input wire logic MCLK,
    // register port toward the option register
    output logic REG_WR,
    output logic [7:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        REG_WR = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 16'h0000;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge MCLK);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge MCLK);
        REG_WR = 1'b0;
        // stale data is inverted so nothing can lean on it
        REG_WDATA = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge MCLK);
        REG_ADDR = a;
        @(negedge MCLK);
        @(negedge MCLK);
        d = REG_RDATA;
    endtask : rd
endmodule : cow_host_model

/* File: verification/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WS = 20;
    localparam int WM = 40;
    localparam int WL = 60;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic bat_n = 1'b1;
    logic adapter = 1'b0;
    logic otg = 1'b0;
    logic lpt = 1'b0;
    logic ce = 1'b1;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic src_good, chg_clr, wd_exp, loop_en, lp_act, internal_regulator_en;
    logic thr_en, mon_en, cmp_en, adc_en, audio, sw400, ripple;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int clr_seen = 0;
    logic [15:0] rv;
    logic [15:0] v;
    logic lp;

    always #20 mclk = ~mclk;

    cow_host_model host_i (.MCLK(mclk), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

    cow_option_zero #(.WD_SHORT_CYCLES(33'(WS)), .WD_MID_CYCLES(33'(WM)),
        .WD_LONG_CYCLES(33'(WL))) cow_option_zero_i (
        .MCLK(mclk), .NRST(nrst), .CE(ce), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .BATTERY_PRESENT_N(bat_n), .ADAPTER_PRESENT(adapter),
        .OTG_MODE(otg), .LOWPOWER_THROTTLE_ENABLE(lpt),
        .SOURCE_GOOD_OUTPUT(src_good), .CHARGE_CURRENT_CLEAR(chg_clr),
        .WATCHDOG_EXPIRED(wd_exp), .INPUT_LIMIT_LOOP_ENABLE(loop_en),
        .LOW_POWER_ACTIVE(lp_act), .INTERNAL_REGULATOR_ENABLE(internal_regulator_en),
        .THROTTLE_ALERT_ENABLE(thr_en), .MONITOR_BUFFER_ENABLE(mon_en),
        .COMPARATOR_ENABLE(cmp_en), .ADC_ENABLE(adc_en),
        .AUDIO_BAND_CLAMP(audio), .SWITCH_AT_400K(sw400),
        .RIPPLE_REDUCE(ripple));

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // falling edge keeps the pulse count clear of the launching edge
    always @(negedge mclk) begin
        cycles++;
        if (chg_clr === 1'b1) begin
            clr_seen++;
        end
        // ceiling far above the thousand or so cycles the tests need
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] %0t run hung", $time);
            test_done();
        end
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                            input string msg);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp, input string msg);
        chk_word({15'h0000, got}, {15'h0000, exp}, msg);
    endtask : chk_flag

    function automatic int exp_period(input logic [1:0] c);
        case (c)
            2'h1: return WS;
            2'h2: return WM;
            2'h3: return WL;
            default: return 200;
        endcase
    endfunction : exp_period

    task automatic wd_test(input logic [1:0] code, input logic [7:0] ra);
        int n;
        int e;
        logic [15:0] opt;
        opt = {1'b0, code, 13'h070e};
        e = exp_period(code);
        n = 0;
        host_i.wr(cow_pkg::ADDR_OPTION0, opt);
        host_i.wr(cow_pkg::ADDR_CHG_CURRENT, 16'h0400);
        while (chg_clr !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk_flag(n >= e - 2 && n <= e + 3, 1'b1, "expiry time");
        if (code != 2'h0) begin
            @(negedge mclk);
            chk_flag(wd_exp, 1'b1, "expired level");
            host_i.wr(ra, (ra == cow_pkg::ADDR_OPTION0) ? opt : 16'h0200);
            @(negedge mclk);
            chk_flag(wd_exp, 1'b0, "restart");
        end
        $display("watchdog code %0d done", code);
    endtask : wd_test

    task automatic bat_test(input logic auto_off);
        logic [15:0] opt;
        opt = {3'h3, auto_off, 12'h70e};
        host_i.wr(cow_pkg::ADDR_OPTION0, opt);
        @(negedge mclk);
        bat_n = 1'b0;
        repeat (6) @(negedge mclk);
        chk_flag(loop_en, !auto_off, "auto clear");
        host_i.rd(cow_pkg::ADDR_OPTION0, rv);
        chk_flag(rv[1], !auto_off, "loop bit read");
        host_i.wr(cow_pkg::ADDR_OPTION0, opt);
        repeat (3) @(negedge mclk);
        chk_flag(loop_en, 1'b1, "re-enable");
        bat_n = 1'b1;
        repeat (4) @(negedge mclk);
        $display("battery auto_off %0d done", auto_off);
    endtask : bat_test

    initial begin
        int k;
        void'($urandom(32'h9b0a));
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        host_i.rd(cow_pkg::ADDR_OPTION0, rv);
        chk_word(rv, 16'he70e, "reset value");
        chk_flag(loop_en & audio & sw400 & ripple, 1'b1, "reset outs");
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            v = 16'($urandom());
            @(negedge mclk);
            adapter = 1'($urandom());
            otg = 1'($urandom());
            lpt = 1'($urandom());
            // host keeps low power off while an adapter is present
            // recommended host practice
            v[15] = v[15] & !adapter;
            host_i.wr(cow_pkg::ADDR_OPTION0, v);
            host_i.wr(8'h06, ~v);
            host_i.rd(cow_pkg::ADDR_OPTION0, rv);
            chk_word(rv, v, "readback");
            host_i.rd(8'h06, rv);
            chk_word(rv, 16'h0000, "unmapped read");
            lp = v[15] & !adapter & bat_n;
            chk_flag(audio, v[10], "audio clamp");
            chk_flag(sw400, v[9], "switch rate");
            chk_flag(ripple, v[8], "ripple");
            chk_flag(loop_en, v[1], "loop enable");
            chk_flag(src_good, adapter | (otg & v[11]), "source good");
            chk_flag(lp_act, lp, "low power");
            chk_flag(internal_regulator_en & adc_en & mon_en, !lp, "regulator");
            chk_flag(cmp_en, !lp | lpt, "comparator");
            chk_flag(thr_en, !lp | lpt, "throttle");
        end
        $display("random register test done");
        wd_test(2'h0, cow_pkg::ADDR_CHG_CURRENT);
        wd_test(2'h1, cow_pkg::ADDR_OPTION0);
        wd_test(2'h2, cow_pkg::ADDR_CHG_VOLTAGE);
        wd_test(2'h3, cow_pkg::ADDR_CHG_CURRENT);
        host_i.wr(cow_pkg::ADDR_OPTION0, 16'h270e);
        k = clr_seen;
        for (int i = 0; i < 6; i++) begin
            repeat (12) @(negedge mclk);
            host_i.wr(i[0] ? cow_pkg::ADDR_CHG_VOLTAGE
                           : cow_pkg::ADDR_CHG_CURRENT, 16'h0100);
        end
        chk_word(16'(clr_seen - k), 16'h0000, "kicked watchdog");
        $display("watchdog kick test done");
        ce = 1'b0;
        k = clr_seen;
        repeat (40) @(negedge mclk);
        chk_word(16'(clr_seen - k), 16'h0000, "frozen watchdog");
        chk_flag(wd_exp, 1'b0, "frozen expiry");
        ce = 1'b1;
        $display("clock enable test done");
        bat_test(1'b1);
        bat_test(1'b0);
        test_done();
    end
endmodule : tb_top
